// ===== voltage_monitor_channel_config.sv
`timescale 1ns/1ps
module voltage_monitor_channel_config #(
    parameter int DEB_BASE_PS = vmon_cfg_pkg::DEB_BASE_PS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd_en,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rd_valid,
    // Channel two comparators
    input  wire logic        hf_over_cmp_two,
    input  wire logic        hf_under_cmp_two,
    // Channel three samples and scale
    input  wire logic [12:0] sense_channel_three_hf_mv,
    input  wire logic [12:0] sense_channel_three_lf_mv,
    input  wire logic        channel_scale_select,
    // Channel two results
    output logic             hf_over_fault_two,
    output logic             hf_under_fault_two,
    output logic      [2:0]  lf_cutoff_sel,
    output logic      [12:0] lf_cutoff_hz,
    output logic             lf_cutoff_valid,
    // Channel three results
    output logic             hf_over_fault_three,
    output logic             hf_under_fault_three,
    output logic             lf_under_fault_three,
    // Reset output
    output logic             reset_out_n
);

    logic [7:0]  debounce_q;
    logic [7:0]  cutoff_q;
    logic [7:0]  hf_under_thr_q;
    logic [7:0]  hf_over_thr_q;
    logic [7:0]  lf_under_thr_q;
    logic        hf_over_fault_to_reset;
    logic        hf_under_fault_to_reset;
    logic [1:0]  cmp_raw;
    logic [1:0]  cmp_qual;
    logic [7:0]  deb_fields [1:0];
    logic [12:0] hf_under_mv;
    logic [12:0] hf_over_mv;
    logic [12:0] lf_under_mv;

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            debounce_q     <= vmon_cfg_pkg::RST_DEBOUNCE;
            cutoff_q       <= vmon_cfg_pkg::RST_CUTOFF;
            hf_under_thr_q <= vmon_cfg_pkg::RST_THRESH;
            hf_over_thr_q  <= vmon_cfg_pkg::RST_THRESH;
            lf_under_thr_q <= vmon_cfg_pkg::RST_THRESH;
        end else if (reg_wr_en) begin
            case (reg_addr)
                vmon_cfg_pkg::OFS_CH2_HF_DEBOUNCE: begin
                    debounce_q <= reg_wdata;
                end
                vmon_cfg_pkg::OFS_CH2_LF_CUTOFF_MAP: begin
                    cutoff_q <= {3'h0, reg_wdata[4:0]};
                end
                vmon_cfg_pkg::OFS_CH3_HF_UNDER_THRESH: begin
                    hf_under_thr_q <= reg_wdata;
                end
                vmon_cfg_pkg::OFS_CH3_HF_OVER_THRESH: begin
                    hf_over_thr_q <= reg_wdata;
                end
                vmon_cfg_pkg::OFS_CH3_LF_UNDER_THRESH: begin
                    lf_under_thr_q <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                case (reg_addr)
                    vmon_cfg_pkg::OFS_CH2_HF_DEBOUNCE:
                        reg_rdata <= debounce_q;
                    vmon_cfg_pkg::OFS_CH2_LF_CUTOFF_MAP:
                        reg_rdata <= cutoff_q;
                    vmon_cfg_pkg::OFS_CH3_HF_UNDER_THRESH:
                        reg_rdata <= hf_under_thr_q;
                    vmon_cfg_pkg::OFS_CH3_HF_OVER_THRESH:
                        reg_rdata <= hf_over_thr_q;
                    vmon_cfg_pkg::OFS_CH3_LF_UNDER_THRESH:
                        reg_rdata <= lf_under_thr_q;
                    default:
                        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ************************************************************
    // Channel two debounce
    // ************************************************************
    assign cmp_raw       = {hf_over_cmp_two, hf_under_cmp_two};
    assign deb_fields[1] = debounce_q >> vmon_cfg_pkg::DEB_OVER_LSB;
    assign deb_fields[0] = debounce_q >> vmon_cfg_pkg::DEB_UNDER_LSB;

    for (genvar i = 0; i < 2; i++) begin : g_deb
        fault_debounce #(
            .BASE_PS (DEB_BASE_PS),
            .CNT_W   (16)
        ) u_deb (
            .clk_sys   (clk_sys),
            .rst_n     (rst_n),
            .raw       (cmp_raw[i]),
            .sel       (deb_fields[i][3:0]),
            .qualified (cmp_qual[i])
        );
    end

    assign hf_over_fault_two  = cmp_qual[1];
    assign hf_under_fault_two = cmp_qual[0];

    // ************************************************************
    // Reset mapping
    // ************************************************************
    assign hf_over_fault_to_reset  = cutoff_q[vmon_cfg_pkg::MAP_OVER_BIT];
    assign hf_under_fault_to_reset = cutoff_q[vmon_cfg_pkg::MAP_UNDER_BIT];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reset_out_n <= 1'b1;
        end else begin
            reset_out_n <= !((cmp_qual[1] && hf_over_fault_to_reset) ||
                             (cmp_qual[0] && hf_under_fault_to_reset));
        end
    end

    // ************************************************************
    // Cutoff decode
    // ************************************************************
    assign lf_cutoff_sel = cutoff_q[vmon_cfg_pkg::CUTOFF_LSB +: 3];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lf_cutoff_hz    <= 13'h0000;
            lf_cutoff_valid <= 1'b0;
        end else begin
            lf_cutoff_valid <= 1'b1;
            case (lf_cutoff_sel)
                vmon_cfg_pkg::CUT_250: lf_cutoff_hz <= vmon_cfg_pkg::HZ_250;
                vmon_cfg_pkg::CUT_500: lf_cutoff_hz <= vmon_cfg_pkg::HZ_500;
                vmon_cfg_pkg::CUT_1K:  lf_cutoff_hz <= vmon_cfg_pkg::HZ_1K;
                vmon_cfg_pkg::CUT_2K:  lf_cutoff_hz <= vmon_cfg_pkg::HZ_2K;
                vmon_cfg_pkg::CUT_4K:  lf_cutoff_hz <= vmon_cfg_pkg::HZ_4K;
                default: begin
                    lf_cutoff_hz    <= 13'h0000;
                    lf_cutoff_valid <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Threshold scaling
    // ************************************************************
    function automatic logic [12:0] thr_mv(input logic [7:0] code,
                                           input logic       scale4);
        logic [12:0] c;
        c = {5'h00, code};
        if (scale4) begin
            thr_mv = 13'(vmon_cfg_pkg::MV_BASE_4X +
                         vmon_cfg_pkg::MV_STEP_4X * c);
        end else begin
            thr_mv = 13'(vmon_cfg_pkg::MV_BASE_1X +
                         vmon_cfg_pkg::MV_STEP_1X * c);
        end
    endfunction : thr_mv

    assign hf_under_mv = thr_mv(hf_under_thr_q, channel_scale_select);
    assign hf_over_mv  = thr_mv(hf_over_thr_q, channel_scale_select);
    assign lf_under_mv = thr_mv(lf_under_thr_q, channel_scale_select);

    // ************************************************************
    // Channel three comparisons
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hf_under_fault_three <= 1'b0;
            hf_over_fault_three  <= 1'b0;
            lf_under_fault_three <= 1'b0;
        end else begin
            hf_under_fault_three <= sense_channel_three_hf_mv < hf_under_mv;
            hf_over_fault_three  <= sense_channel_three_hf_mv > hf_over_mv;
            lf_under_fault_three <= sense_channel_three_lf_mv < lf_under_mv;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_map_over_reset: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cmp_qual[1] && cutoff_q[4]) |=> !reset_out_n)
        else $error("mapped over fault did not pull reset");

    a_map_under_reset: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cmp_qual[0] && cutoff_q[3]) |=> !reset_out_n)
        else $error("mapped under fault did not pull reset");

    a_unmapped_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!(cmp_qual[1] && cutoff_q[4]) && !(cmp_qual[0] && cutoff_q[3]))
        |=> reset_out_n)
        else $error("reset pulled without a mapped fault");

    a_unmapped_idle: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!cutoff_q[4] && !cutoff_q[3]) |=> reset_out_n)
        else $error("reset pulled with no fault mapped");

    a_cut_decode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cutoff_q[2:0] == 3'h2) |=> (lf_cutoff_hz == 13'h00FA &&
                                     lf_cutoff_valid))
        else $error("code 2 not decoded as 250 Hz");

    a_cut_top: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cutoff_q[2:0] == 3'h6) |=> (lf_cutoff_hz == 13'h0FA0 &&
                                     lf_cutoff_valid))
        else $error("code 6 not decoded as 4 kHz");

    a_cut_invalid: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cutoff_q[2:0] == 3'h7 || cutoff_q[2:1] == 2'h0)
        |=> !lf_cutoff_valid)
        else $error("invalid cutoff code reported valid");

    a_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_wr_en && reg_addr == 8'h35 |=> cutoff_q[7:5] == 3'h0)
        else $error("reserved cutoff bits stored");

    a_rd_reserved: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_en && reg_addr == 8'h35) |=> reg_rdata[7:5] == 3'h0)
        else $error("reserved cutoff bits read back set");

    a_wr_debounce: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr_en && reg_addr == 8'h34) |=> debounce_q == $past(reg_wdata))
        else $error("debounce setting not stored");

    a_scale_one: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !channel_scale_select |->
        hf_under_mv == 13'(13'd200 + 13'd5 * {5'h00, hf_under_thr_q}))
        else $error("1x threshold wrong");

    a_scale_four: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        channel_scale_select |->
        hf_over_mv == 13'(13'd800 + 13'd20 * {5'h00, hf_over_thr_q}))
        else $error("4x threshold wrong");

    a_scale_lf: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        channel_scale_select |->
        lf_under_mv == 13'(13'd800 + 13'd20 * {5'h00, lf_under_thr_q}))
        else $error("4x low-frequency threshold wrong");

    a_hf_under_cmp: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (sense_channel_three_hf_mv < hf_under_mv) |=> hf_under_fault_three)
        else $error("under fault missed");

    a_hf_under_off: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (sense_channel_three_hf_mv >= hf_under_mv) |=> !hf_under_fault_three)
        else $error("under fault without crossing");

    a_hf_over_cmp: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (sense_channel_three_hf_mv <= hf_over_mv) |=> !hf_over_fault_three)
        else $error("over fault without crossing");

    a_hf_over_hit: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (sense_channel_three_hf_mv > hf_over_mv) |=> hf_over_fault_three)
        else $error("over fault missed");

    a_lf_under_cmp: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (sense_channel_three_lf_mv < lf_under_mv) |=> lf_under_fault_three)
        else $error("low-frequency under fault missed");

    a_lf_under_off: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (sense_channel_three_lf_mv >= lf_under_mv) |=> !lf_under_fault_three)
        else $error("low-frequency under fault without crossing");

endmodule : voltage_monitor_channel_config

// ===== vmon_cfg_pkg.sv
package vmon_cfg_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CH2_HF_DEBOUNCE       = 8'h34;
    localparam logic [7:0] OFS_CH2_LF_CUTOFF_MAP     = 8'h35;
    localparam logic [7:0] OFS_CH3_HF_UNDER_THRESH   = 8'h40;
    localparam logic [7:0] OFS_CH3_HF_OVER_THRESH    = 8'h41;
    localparam logic [7:0] OFS_CH3_LF_UNDER_THRESH   = 8'h42;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DEB_OVER_LSB  = 4;
    localparam int DEB_UNDER_LSB = 0;
    localparam int MAP_OVER_BIT  = 4;
    localparam int MAP_UNDER_BIT = 3;
    localparam int CUTOFF_LSB    = 0;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] RST_DEBOUNCE = 8'h00;
    localparam logic [7:0] RST_CUTOFF   = 8'h00;
    localparam logic [7:0] RST_THRESH   = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int DEB_BASE_PS     = 100000;
    localparam int DEB_SHIFT_MAX   = 10;

    // ************************************************************
    // Threshold scaling, millivolts
    // ************************************************************
    localparam logic [12:0] MV_BASE_1X = 13'h00C8;
    localparam logic [12:0] MV_STEP_1X = 13'h0005;
    localparam logic [12:0] MV_BASE_4X = 13'h0320;
    localparam logic [12:0] MV_STEP_4X = 13'h0014;

    // ************************************************************
    // Cutoff codes and frequencies
    // ************************************************************
    localparam logic [2:0]  CUT_250  = 3'h2;
    localparam logic [2:0]  CUT_500  = 3'h3;
    localparam logic [2:0]  CUT_1K   = 3'h4;
    localparam logic [2:0]  CUT_2K   = 3'h5;
    localparam logic [2:0]  CUT_4K   = 3'h6;
    localparam logic [12:0] HZ_250   = 13'h00FA;
    localparam logic [12:0] HZ_500   = 13'h01F4;
    localparam logic [12:0] HZ_1K    = 13'h03E8;
    localparam logic [12:0] HZ_2K    = 13'h07D0;
    localparam logic [12:0] HZ_4K    = 13'h0FA0;

endpackage : vmon_cfg_pkg

// ===== fault_debounce.sv
`timescale 1ns/1ps
module fault_debounce #(
    parameter int BASE_PS = vmon_cfg_pkg::DEB_BASE_PS,
    parameter int CNT_W   = 16
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Comparator and code
    input  wire logic       raw,
    input  wire logic [3:0] sel,
    // Qualified fault
    output logic            qualified
);

    // ************************************************************
    // Code to cycle count
    // ************************************************************
    function automatic logic [CNT_W-1:0] deb_cycles(input logic [3:0] code);
        int sh;
        int ps;
        sh = (int'(code) > vmon_cfg_pkg::DEB_SHIFT_MAX) ?
             vmon_cfg_pkg::DEB_SHIFT_MAX : int'(code);
        ps = BASE_PS << sh;
        deb_cycles = CNT_W'((ps + vmon_cfg_pkg::CLK_PERIOD_PS - 1)
                            / vmon_cfg_pkg::CLK_PERIOD_PS);
    endfunction : deb_cycles

    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] run_q;

    assign target = deb_cycles(sel);

    // ************************************************************
    // Stable-time counter
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q     <= '0;
            qualified <= 1'b0;
        end else if (!raw) begin
            cnt_q     <= '0;
            qualified <= 1'b0;
        end else if (cnt_q >= target) begin
            qualified <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !raw) begin
            run_q <= '0;
        end else if (run_q != {CNT_W{1'b1}}) begin
            run_q <= run_q + 1'b1;
        end
    end

    a_deb_restart: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !raw |=> !qualified)
        else $error("fault kept after comparator dropped");

    a_deb_min_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ($rose(qualified) && $stable(sel)) |-> (run_q > target))
        else $error("fault qualified before debounce time");

    a_deb_fires: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ($stable(sel) && run_q > target) |-> qualified)
        else $error("debounced fault not reported in time");

endmodule : fault_debounce

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr_en = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd_en = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_rd_valid;
    logic        ov_cmp = 1'b0;
    logic        uv_cmp = 1'b0;
    logic [12:0] hf_mv = 13'h0000;
    logic [12:0] lf_mv = 13'h0000;
    logic        scale = 1'b0;
    logic        ov2, uv2, ov3, uv3, lfuv3, rst_out_n, cut_ok;
    logic [2:0]  cut_sel;
    logic [12:0] cut_hz;
    int          errors = 0;
    int          samples_checked = 0;
    int          mdl[int];
    logic [7:0]  rv;
    int          deb_codes[6] = '{0, 1, 4, 9, 10, 15};

    always #4 clk_sys = ~clk_sys;

    voltage_monitor_channel_config #(.DEB_BASE_PS(8000)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .hf_over_cmp_two(ov_cmp),
        .hf_under_cmp_two(uv_cmp), .sense_channel_three_hf_mv(hf_mv),
        .sense_channel_three_lf_mv(lf_mv), .channel_scale_select(scale),
        .hf_over_fault_two(ov2), .hf_under_fault_two(uv2),
        .lf_cutoff_sel(cut_sel), .lf_cutoff_hz(cut_hz),
        .lf_cutoff_valid(cut_ok), .hf_over_fault_three(ov3),
        .hf_under_fault_three(uv3), .lf_under_fault_three(lfuv3),
        .reset_out_n(rst_out_n));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        if (mdl.exists(a)) mdl[a] = (a == 8'h35) ? (d & 8'h1F) : d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        while (reg_rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (reg_rd_valid !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
        d = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a);
        rd(a, rv);
        chk(rv, mdl.exists(a) ? mdl[a] : 0);
    endtask : rd_chk

    function automatic int hz_of(input int c);
        case (c)
            2: return 250;
            3: return 500;
            4: return 1000;
            5: return 2000;
            6: return 4000;
            default: return 0;
        endcase
    endfunction : hz_of

    // ****************************************************************
    // Debounce of a full excursion
    // ****************************************************************
    task automatic deb(input int code);
        int n;
        n = (code >= 10) ? 1024 : (1 << code);
        wr({code[3:0], code[3:0]}, 8'h00);
        wr(8'h34, {code[3:0], code[3:0]});
        @(posedge clk_sys);
        ov_cmp <= 1'b1;
        uv_cmp <= 1'b1;
        repeat (n) @(posedge clk_sys);
        #1;
        chk({ov2, uv2}, 2'b00);
        @(posedge clk_sys);
        ov_cmp <= 1'b0;
        uv_cmp <= 1'b0;
        #1;
        chk({ov2, uv2}, 2'b11);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({ov2, uv2}, 2'b00);
    endtask : deb

    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int c, thu, tho, thl, base, step, hu, ho, hl;
        mdl[8'h34] = 0;
        mdl[8'h35] = 0;
        mdl[8'h40] = 0;
        mdl[8'h41] = 0;
        mdl[8'h42] = 0;
        void'($urandom(73));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk({rst_out_n, ov2, uv2, cut_ok}, 4'b1000);
        foreach (mdl[a]) rd_chk(a[7:0]);
        wr(8'h36, 8'hAA);
        rd_chk(8'h36);
        // Valid cutoff codes only, reserved bits set
        for (c = 2; c < 7; c++) begin
            wr(8'h35, 8'hE0 | c[7:0]);
            @(posedge clk_sys);
            #1;
            chk(cut_sel, c);
            chk(cut_hz, hz_of(c));
            chk(cut_ok, (c >= 2 && c <= 6));
            rd_chk(8'h35);
        end
        foreach (deb_codes[i]) begin
            deb(deb_codes[i]);
        end
        // Interrupted excursion restarts the count
        wr(8'h34, 8'h33);
        @(posedge clk_sys);
        ov_cmp <= 1'b1;
        repeat (5) @(posedge clk_sys);
        ov_cmp <= 1'b0;
        @(posedge clk_sys);
        ov_cmp <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        chk(ov2, 1'b0);
        @(posedge clk_sys);
        #1;
        chk({ov2, uv2}, 2'b10);
        // Reset routing, both faults active
        wr(8'h34, 8'h00);
        uv_cmp <= 1'b1;
        for (c = 0; c < 4; c++) begin
            wr(8'h35, {3'h0, c[1:0], 3'h2});
            repeat (4) @(posedge clk_sys);
            #1;
            chk(rst_out_n, !(c[1] | c[0]));
        end
        // Over fault gone, under fault still mapped
        @(posedge clk_sys);
        ov_cmp <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(rst_out_n, 1'b0);
        @(posedge clk_sys);
        uv_cmp <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(rst_out_n, 1'b1);
        // Channel three thresholds, random
        for (c = 0; c < 40; c++) begin
            thu = $urandom % 256;
            tho = $urandom % 256;
            thl = $urandom % 256;
            wr(8'h40, thu[7:0]);
            wr(8'h41, tho[7:0]);
            wr(8'h42, thl[7:0]);
            @(posedge clk_sys);
            scale <= c[0];
            base = c[0] ? 800 : 200;
            step = c[0] ? 20 : 5;
            hu = base + step * thu;
            ho = base + step * tho;
            hl = base + step * thl;
            hf_mv <= (c[1] ? hu : ho) + ($urandom % 5) - 2;
            lf_mv <= hl + ($urandom % 5) - 2;
            @(posedge clk_sys);
            @(posedge clk_sys);
            #1;
            chk(uv3, hf_mv < hu);
            chk(ov3, hf_mv > ho);
            chk(lfuv3, lf_mv < hl);
            rd_chk(8'h40 + c[7:0] % 3);
        end
        tally_and_finish();
    end

endmodule : testbench
